// ### tmb_defs.vh
// register indices, field positions, reset values and prescaler terminal counts
// of the 16-bit timer/counter; included by every design file
`ifndef TMB_DEFS_VH
`define TMB_DEFS_VH

// ***********************************************************************
// register indices (byte address is four times the index)
// ***********************************************************************
`define TMB_IDX_CTRL 6'h06
`define TMB_IDX_RELOAD 6'h07
`define TMB_IDX_COUNT 6'h0a
`define TMB_IDX_COMPARE 6'h0b

// ***********************************************************************
// control register fields
// ***********************************************************************
`define TMB_B_CTSEL 15
`define TMB_B_OSET 12
`define TMB_B_OCLR 11
`define TMB_B_PSEL_HI 10
`define TMB_B_PSEL_LO 8
`define TMB_B_OVF 7
`define TMB_B_EXT 6
`define TMB_B_CKOE 5
`define TMB_B_DOWN_COUNT_ENABLE 4
`define TMB_B_EXEN 3
`define TMB_B_RUN 2
`define TMB_B_IE 1
`define TMB_B_CPSEL 0

// ***********************************************************************
// reset values
// ***********************************************************************
`define TMB_RST_16 16'h0000

// ***********************************************************************
// prescaler terminal counts (divide minus one)
// ***********************************************************************
`define TMB_PS_DIV1 10'h000
`define TMB_PS_DIV4 10'h003
`define TMB_PS_DIV16 10'h00f
`define TMB_PS_DIV64 10'h03f
`define TMB_PS_DIV256 10'h0ff
`define TMB_PS_DIV1024 10'h3ff

// ***********************************************************************
// bus answers
// ***********************************************************************
`define TMB_RESP_OKAY 2'b00
`define TMB_RESP_SLVERR 2'b10

`endif

// ### tmb_prescale.v
// clock prescaler: one-cycle tick every 1..1024 system clocks
// assumes sel is only changed while run is low
`timescale 1ns/1ps
`include "tmb_defs.vh"

module tmb_prescale (
    input wire clk,
    input wire rst,
    input wire run,
    input wire [2:0] sel,
    output wire tick
);

    reg [9:0] cnt_r;
    reg [9:0] term;

    always @* begin
        case (sel)
            3'b001: term = `TMB_PS_DIV4;
            3'b010: term = `TMB_PS_DIV16;
            3'b011: term = `TMB_PS_DIV64;
            3'b100: term = `TMB_PS_DIV256;
            3'b101: term = `TMB_PS_DIV1024;
            default: term = `TMB_PS_DIV1;
        endcase
    end

    assign tick = run && (cnt_r == term);

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 10'h000;
        end else if (!run || cnt_r == term) begin
            cnt_r <= 10'h000;
        end else begin
            cnt_r <= cnt_r + 10'h001;
        end
    end

endmodule // tmb_prescale

// ### tmb_axil.v
// axi4-lite slave front end: one write and one read at a time
// assumes the core returns read data combinationally for rd_idx
`timescale 1ns/1ps
`include "tmb_defs.vh"

module tmb_axil #(
    parameter AW = 8
) (
    input wire clk,
    input wire rst,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg wr_pulse,
    output reg [5:0] wr_idx,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    output wire [5:0] rd_idx,
    input wire [31:0] rd_data
);

    reg aw_held_r;
    reg w_held_r;
    wire [5:0] ar_idx = s_axi_araddr[7:2];

    function hit;
        input [5:0] idx;
        begin
            hit = (idx == `TMB_IDX_CTRL) || (idx == `TMB_IDX_RELOAD) ||
                (idx == `TMB_IDX_COUNT) || (idx == `TMB_IDX_COMPARE);
        end
    endfunction

    assign rd_idx = ar_idx;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TMB_RESP_OKAY;
            wr_pulse <= 1'b0;
            wr_idx <= 6'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `TMB_RESP_OKAY;
        end else begin
            wr_pulse <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_idx <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            // both halves present: pulse the write and raise the answer in the same cycle
            if (aw_held_r && w_held_r && !s_axi_bvalid) begin
                wr_pulse <= hit(wr_idx);
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= hit(wr_idx) ? `TMB_RESP_OKAY :
                    `TMB_RESP_SLVERR;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= hit(ar_idx) ? rd_data : 32'h00000000;
                s_axi_rresp <= hit(ar_idx) ? `TMB_RESP_OKAY :
                    `TMB_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // tmb_axil

// ### tmb_timer.v
// 16-bit timer/counter with prescaler, capture/reload and compare
// registers behind an axi4-lite slave; pins are synchronous to clk
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "tmb_defs.vh"

module tmb_timer #(
    parameter AW = 8
) (
    input wire clk,
    input wire rst,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire count_input_pin_in,
    output reg count_input_pin_out,
    output reg count_input_pin_oe,
    input wire trigger_direction_pin_in,
    output reg trigger_direction_pin_out,
    output reg trigger_direction_pin_oe,
    output reg timer_irq_r
);

    // *******************************************************************
    // state
    // *******************************************************************
    reg counter_timer_select_r;
    reg output_set_mode_bit_r;
    reg output_clear_mode_bit_r;
    reg [2:0] prescaler_select_r;
    reg overflow_flag_r;
    reg external_trigger_flag_r;
    reg clock_output_enable_r;
    reg down_count_enable_r;
    reg external_pin_enable_r;
    reg run_control_r;
    reg interrupt_enable_r;
    reg capture_reload_select_r;
    reg [15:0] count_value_r;
    reg [15:0] capture_reload_value_r;
    reg [15:0] compare_value_r;
    reg trig_prev_r;
    reg cnt_prev_r;
    reg tri_up_r;
    reg pwm_r;

    wire wr_pulse;
    wire [5:0] wr_idx;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire [5:0] rd_idx;
    reg [31:0] rd_data;
    wire presc_tick;

    // *******************************************************************
    // bus slave and prescaler
    // *******************************************************************
    tmb_axil #(
        .AW(AW)
    ) u_axil (
        .clk(clk),
        .rst(rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_pulse(wr_pulse),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .rd_idx(rd_idx),
        .rd_data(rd_data)
    );

    tmb_prescale u_presc (
        .clk(clk),
        .rst(rst),
        .run(run_control_r),
        .sel(prescaler_select_r),
        .tick(presc_tick)
    );

    // *******************************************************************
    // register read view
    // *******************************************************************
    wire [15:0] ctrl_view = {counter_timer_select_r, 2'b00,
        output_set_mode_bit_r, output_clear_mode_bit_r, prescaler_select_r,
        overflow_flag_r, external_trigger_flag_r, clock_output_enable_r,
        down_count_enable_r, external_pin_enable_r, run_control_r,
        interrupt_enable_r, capture_reload_select_r};

    always @* begin
        case (rd_idx)
            `TMB_IDX_CTRL: rd_data = {16'h0000, ctrl_view};
            `TMB_IDX_RELOAD: rd_data = {16'h0000, capture_reload_value_r};
            `TMB_IDX_COUNT: rd_data = {16'h0000, count_value_r};
            `TMB_IDX_COMPARE: rd_data = {16'h0000, compare_value_r};
            default: rd_data = 32'h00000000;
        endcase
    end

    function [15:0] lane_merge;
        input [15:0] old;
        input [15:0] data;
        input [1:0] strb;
        begin
            lane_merge = {strb[1] ? data[15:8] : old[15:8],
                strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    wire wr_ctrl = wr_pulse && (wr_idx == `TMB_IDX_CTRL);
    wire wr_rel = wr_pulse && (wr_idx == `TMB_IDX_RELOAD);
    wire wr_cnt = wr_pulse && (wr_idx == `TMB_IDX_COUNT);
    wire wr_cmp = wr_pulse && (wr_idx == `TMB_IDX_COMPARE);
    wire [15:0] ctrl_w = lane_merge(ctrl_view, wr_data[15:0], wr_strb[1:0]);

    // *******************************************************************
    // mode decode
    // *******************************************************************
    wire out_mode = (output_set_mode_bit_r | output_clear_mode_bit_r) &&
        !capture_reload_select_r;
    wire clk_out_mode = clock_output_enable_r &&
        !counter_timer_select_r;
    wire toggle_mode = !capture_reload_select_r && down_count_enable_r &&
        !out_mode;
    wire trig_fall = trig_prev_r & ~trigger_direction_pin_in;
    wire cnt_fall = cnt_prev_r & ~count_input_pin_in;
    wire step = run_control_r && (counter_timer_select_r ? cnt_fall :
        presc_tick);
    wire count_up = capture_reload_select_r || !down_count_enable_r ||
        (out_mode ? tri_up_r : trigger_direction_pin_in);
    wire pwm_init = output_clear_mode_bit_r && !output_set_mode_bit_r;

    // *******************************************************************
    // counter next state
    // *******************************************************************
    reg [15:0] count_nxt;
    reg roll;
    reg ext_reload;

    always @* begin
        count_nxt = count_value_r;
        roll = 1'b0;
        ext_reload = 1'b0;
        if (step) begin
            if (capture_reload_select_r) begin
                count_nxt = count_value_r + 16'h0001;
                roll = (count_value_r == 16'hffff);
            end else if (count_up) begin
                if (count_value_r == capture_reload_value_r) begin
                    roll = 1'b1;
                    count_nxt = (out_mode && down_count_enable_r) ?
                        count_value_r - 16'h0001 : 16'h0000;
                end else begin
                    count_nxt = count_value_r + 16'h0001;
                end
            end else begin
                if (count_value_r == 16'h0000) begin
                    roll = 1'b1;
                    count_nxt = out_mode ? 16'h0001 :
                        capture_reload_value_r;
                end else begin
                    count_nxt = count_value_r - 16'h0001;
                end
            end
        end
        // pin reload only when the pin is neither output nor direction
        if (external_pin_enable_r && trig_fall && !capture_reload_select_r &&
            !out_mode && !down_count_enable_r) begin
            ext_reload = 1'b1;
            count_nxt = 16'h0000;
        end
        if (wr_cnt) begin
            count_nxt = lane_merge(count_value_r, wr_data[15:0],
                wr_strb[1:0]);
        end
    end

    // *******************************************************************
    // compare output
    // *******************************************************************
    wire cmp_hit = step && out_mode &&
        (count_nxt == compare_value_r);
    reg pwm_nxt;

    always @* begin
        pwm_nxt = pwm_r;
        if (!out_mode) begin
            pwm_nxt = pwm_init;
        end else if (cmp_hit) begin
            case ({output_set_mode_bit_r, output_clear_mode_bit_r})
                2'b10: pwm_nxt = 1'b1;
                2'b01: pwm_nxt = 1'b0;
                2'b11: pwm_nxt = ~pwm_r;
                default: pwm_nxt = pwm_r;
            endcase
        end else if (roll && !down_count_enable_r) begin
            pwm_nxt = pwm_init;
        end
    end

    wire pwm_fall = pwm_r & ~pwm_nxt;

    // *******************************************************************
    // flag events
    // *******************************************************************
    wire capture_ev = external_pin_enable_r && trig_fall &&
        capture_reload_select_r;
    wire ext_set = capture_ev || ext_reload ||
        (external_pin_enable_r && out_mode && pwm_fall);
    wire ext_tog = toggle_mode && roll;
    wire ovf_nxt = roll | (wr_ctrl ? ctrl_w[`TMB_B_OVF] :
        overflow_flag_r);
    wire ext_base = wr_ctrl ? ctrl_w[`TMB_B_EXT] : external_trigger_flag_r;
    wire ext_nxt = ext_tog ? ~external_trigger_flag_r :
        (ext_set | ext_base);
    wire irq_nxt = interrupt_enable_r &&
        ((overflow_flag_r && !clk_out_mode) ||
        (external_trigger_flag_r && !toggle_mode));

    // *******************************************************************
    // registers
    // *******************************************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            counter_timer_select_r <= 1'b0;
            output_set_mode_bit_r <= 1'b0;
            output_clear_mode_bit_r <= 1'b0;
            prescaler_select_r <= 3'b000;
            overflow_flag_r <= 1'b0;
            external_trigger_flag_r <= 1'b0;
            clock_output_enable_r <= 1'b0;
            down_count_enable_r <= 1'b0;
            external_pin_enable_r <= 1'b0;
            run_control_r <= 1'b0;
            interrupt_enable_r <= 1'b0;
            capture_reload_select_r <= 1'b0;
            count_value_r <= `TMB_RST_16;
            capture_reload_value_r <= `TMB_RST_16;
            compare_value_r <= `TMB_RST_16;
            trig_prev_r <= 1'b0;
            cnt_prev_r <= 1'b0;
            tri_up_r <= 1'b1;
            pwm_r <= 1'b0;
            count_input_pin_out <= 1'b0;
            count_input_pin_oe <= 1'b0;
            trigger_direction_pin_out <= 1'b0;
            trigger_direction_pin_oe <= 1'b0;
            timer_irq_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                counter_timer_select_r <= ctrl_w[`TMB_B_CTSEL];
                output_set_mode_bit_r <= ctrl_w[`TMB_B_OSET];
                output_clear_mode_bit_r <= ctrl_w[`TMB_B_OCLR];
                prescaler_select_r <=
                    ctrl_w[`TMB_B_PSEL_HI:`TMB_B_PSEL_LO];
                clock_output_enable_r <= ctrl_w[`TMB_B_CKOE];
                down_count_enable_r <= ctrl_w[`TMB_B_DOWN_COUNT_ENABLE];
                external_pin_enable_r <= ctrl_w[`TMB_B_EXEN];
                run_control_r <= ctrl_w[`TMB_B_RUN];
                interrupt_enable_r <= ctrl_w[`TMB_B_IE];
                capture_reload_select_r <= ctrl_w[`TMB_B_CPSEL];
            end
            overflow_flag_r <= ovf_nxt;
            external_trigger_flag_r <= ext_nxt;
            count_value_r <= count_nxt;
            if (capture_ev) begin
                capture_reload_value_r <= count_value_r;
            end else if (wr_rel) begin
                capture_reload_value_r <= lane_merge(capture_reload_value_r,
                    wr_data[15:0], wr_strb[1:0]);
            end
            if (wr_cmp) begin
                compare_value_r <= lane_merge(compare_value_r,
                    wr_data[15:0], wr_strb[1:0]);
            end
            trig_prev_r <= trigger_direction_pin_in;
            cnt_prev_r <= count_input_pin_in;
            if (!(out_mode && down_count_enable_r)) begin
                tri_up_r <= 1'b1;
            end else if (step && roll) begin
                tri_up_r <= ~tri_up_r;
            end
            pwm_r <= pwm_nxt;
            // clock output: pin toggles at every rollover
            if (!clk_out_mode) begin
                count_input_pin_out <= 1'b0;
            end else if (roll) begin
                count_input_pin_out <= ~count_input_pin_out;
            end
            count_input_pin_oe <= clk_out_mode;
            trigger_direction_pin_out <= pwm_nxt;
            trigger_direction_pin_oe <= out_mode;
            timer_irq_r <= irq_nxt;
        end
    end

endmodule // tmb_timer

// ### tmb_pin_model.sv
// far-side driver of the count pin and the trigger pin
// assumes both pins idle high while the far side is not pulsing them
`timescale 1ns/1ps
module tmb_pin_model (
    input wire clk,
    input wire a_oe,
    input wire a_out,
    input wire b_oe,
    input wire b_out,
    output wire a_pin,
    output wire b_pin
);
    reg [1:0] lv_r = 2'h3;
    // the timer wins the wire while it drives
    assign a_pin = a_oe ? a_out : lv_r[0];
    assign b_pin = b_oe ? b_out : lv_r[1];
    // n falling edges on the selected pins, each level held two clocks
    task fall(input logic [1:0] sel, input int n);
        repeat (n) begin
            @(posedge clk);
            lv_r <= ~sel;
            repeat (2) @(posedge clk);
            lv_r <= 2'h3;
            @(posedge clk);
        end
    endtask
endmodule // tmb_pin_model

// ### tmb_timer_properties.sv
// bus handshake properties of the timer block
// assumes it is bound to tmb_timer and sees only its ports
`timescale 1ns/1ps
module tmb_timer_properties (
    input wire clk,
    input wire rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("read answer late");
    a_write_lat: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid) else $error("bvalid dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_aw_block: assert property (s_axi_bvalid |->
        !s_axi_awready && !s_axi_wready) else $error("write taken early");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken early");
    a_w_release: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid && s_axi_awready) else $error("write not released");
    a_r_release: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready) else $error("read not released");
endmodule // tmb_timer_properties

// ### tb_top.sv
// self-checking bench of tmb_timer over axi4-lite with a pin model
// assumes indices 06,07,0a,0b at byte addresses four times the index
`timescale 1ns/1ps
module tb_top;
    localparam [7:0] CT = 8'h18, RL = 8'h1c, CN = 8'h28;
    localparam [31:0] AD = 32'h2c281c18;
    reg clk = 1'h0, rst = 1'h1;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, count_input_pin_in, count_input_pin_out;
    wire count_input_pin_oe, trigger_direction_pin_in, timer_irq_r;
    wire trigger_direction_pin_out, trigger_direction_pin_oe;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    reg [1:0] rsp;
    reg [15:0] q, q2;
    int errors = 0, compares = 0;
    always #20 clk = ~clk;
    tmb_timer i_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_input_pin_in,
        .count_input_pin_out, .count_input_pin_oe, .timer_irq_r,
        .trigger_direction_pin_in, .trigger_direction_pin_out,
        .trigger_direction_pin_oe);
    tmb_pin_model i_pins (.clk, .a_oe(count_input_pin_oe),
        .a_out(count_input_pin_out), .b_oe(trigger_direction_pin_oe),
        .b_out(trigger_direction_pin_out), .a_pin(count_input_pin_in),
        .b_pin(trigger_direction_pin_in));
    // ******************************************************************
    // bus tasks and comparison
    // ******************************************************************
    task wr(input [7:0] a, input [15:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_awvalid || s_axi_wvalid);
        while (!s_axi_bvalid) @(posedge clk);
        s_axi_bready <= 1'h1;
        @(posedge clk);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task rd(input [7:0] a, output [15:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        while (!s_axi_rvalid) @(posedge clk);
        s_axi_rready <= 1'h1;
        @(posedge clk);
        d = s_axi_rdata[15:0];
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task chk(input [15:0] g, input [15:0] e);
        compares++;
        if (g !== e)
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        if (g !== e) errors++;
    endtask
    // ******************************************************************
    // scenarios
    // ******************************************************************
    task t_reset;
        for (int i = 0; i < 4; i++) begin
            rd(8'(AD >> (8 * i)), q);
            chk(q, 16'h0000);
        end
        rd(8'h00, q);
        chk(16'(rsp), 16'h0002);
        wr(CT, 16'h6000);
        rd(CT, q);
        chk(q, 16'h0000);
        $display("test reset done");
    endtask
    task t_prescale;
        int d;
        wr(RL, 16'hffff);
        for (int p = 0; p < 8; p++) begin
            d = (p > 5) ? 1 : 4 ** p;
            wr(CT, 16'(p << 8));
            wr(CN, 16'h0000);
            wr(CT, 16'((p << 8) | 4));
            repeat (2048) @(posedge clk);
            wr(CT, 16'(p << 8));
            rd(CN, q);
            chk(16'(q >= 2048 / d && q <= 2048 / d + 8), 16'h0001);
            rd(CN, q2);
            chk(q2, q);
        end
        $display("test prescale done");
    endtask
    task t_count;
        wr(CN, 16'h0000);
        wr(CT, 16'h8004);
        i_pins.fall(2'h1, 5);
        wr(CT, 16'h8000);
        rd(CN, q);
        chk(q, 16'h0005);
        chk(16'(count_input_pin_oe), 16'h0000);
        $display("test counter done");
    endtask
    task t_trigger;
        wr(CN, 16'h1234);
        wr(CT, 16'h0009);
        i_pins.fall(2'h2, 1);
        rd(RL, q);
        chk(q, 16'h1234);
        rd(CT, q);
        chk(q, 16'h0049);
        wr(CT, 16'h0008);
        i_pins.fall(2'h2, 1);
        rd(CN, q);
        chk(q, 16'h0000);
        rd(CT, q);
        chk(q, 16'h0048);
        wr(CT, 16'h0000);
        $display("test trigger done");
    endtask
    task t_ovf;
        wr(RL, 16'h0003);
        wr(CN, 16'h0000);
        wr(CT, 16'h0006);
        repeat (20) @(posedge clk);
        chk(16'(timer_irq_r), 16'h0001);
        rd(CT, q);
        chk(q, 16'h0086);
        rd(CN, q);
        chk(16'(q <= 3), 16'h0001);
        wr(CT, 16'h00a6);
        repeat (3) @(posedge clk);
        chk(16'(count_input_pin_oe), 16'h0001);
        chk(16'(timer_irq_r), 16'h0000);
        wr(CT, 16'h0082);
        wr(CT, 16'h0000);
        repeat (2) @(posedge clk);
        chk(16'(timer_irq_r), 16'h0000);
        wr(CT, 16'h0042);
        repeat (2) @(posedge clk);
        chk(16'(timer_irq_r), 16'h0001);
        wr(CT, 16'h0000);
        $display("test overflow done");
    endtask
    task t_updown;
        wr(CN, 16'hffff);
        wr(CT, 16'h8005);
        i_pins.fall(2'h1, 1);
        rd(CT, q);
        chk(q, 16'h8085);
        wr(RL, 16'h0002);
        wr(CN, 16'h0001);
        wr(CT, 16'h8014);
        i_pins.fall(2'h3, 3);
        rd(CN, q);
        chk(q, 16'h0001);
        rd(CT, q);
        chk(q, 16'h80d4);
        i_pins.fall(2'h1, 2);
        rd(CT, q);
        chk(q, 16'h8094);
        wr(CT, 16'h0052);
        repeat (2) @(posedge clk);
        chk(16'(timer_irq_r), 16'h0000);
        $display("test updown done");
    endtask
    task t_cmp;
        wr(RL, 16'h0005);
        wr(8'h2c, 16'h0002);
        wr(CN, 16'h0000);
        wr(CT, 16'h900c);
        i_pins.fall(2'h1, 2);
        chk(16'(trigger_direction_pin_out), 16'h0001);
        chk(16'(trigger_direction_pin_oe), 16'h0001);
        i_pins.fall(2'h1, 4);
        chk(16'(trigger_direction_pin_out), 16'h0000);
        rd(CT, q);
        chk(q, 16'h90cc);
        $display("test compare done");
    endtask
    task report_and_stop;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        report_and_stop;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_reset;
        t_prescale;
        t_count;
        t_trigger;
        t_ovf;
        t_updown;
        t_cmp;
        report_and_stop;
    end
endmodule // tb_top
bind tmb_timer tmb_timer_properties i_chk (.clk, .rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready);
